// file: logic/isrp_pkg.sv
// Purpose: Constants for the two-wire slave with register pointer
// Assumes: Link lines sampled by a 250 MHz system clock
// Notes on behaviour
// R1: Slave address is fixed bits 11110 then the two address-select pins.
// R2: In write mode, hold data low through the whole ninth clock.
// R3: Stop is seen anywhere; master never puts stop in start's high pulse.
// R4: First write byte after address loads the register pointer.
// R5: Pointer byte is acknowledged on the following ninth clock.
// R6: Each later write byte goes to the pointed register and is acknowledged.
// R7: Pointer advances by one after each received write data byte.
// R8: Write pointer saturates at the top register.
// R9: Read after a plain start resets pointer to zero and returns it first.
// R10: Read address is acknowledged by pulling data low on ninth clock.
// R11: Read data bits are valid at the rising serial clock edge.
// R12: Pointer advances by one after each transmitted read byte.
// R13: Reads end with stop anytime; next plain-start read begins at zero.
// R14: Pointer write, repeated start, read returns chosen register, then advances.
// R15: Read pointer saturates at the top register.
// R16: Master acknowledges every read byte but the last, then stop.
// R17: Pointer reset on read only after plain start, kept after repeated start.
`default_nettype none
package isrp_pkg;
	localparam logic [4:0] ADDR_FIXED = 5'h1E;
	localparam logic [7:0] PTR_TOP = 8'h0B;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam int NUM_REGS = 12;
	localparam logic [3:0] BIT_LAST = 4'h8;
	typedef enum logic [2:0] {
		ISRP_IDLE = 3'b000,
		ISRP_ADDR = 3'b001,
		ISRP_ACK = 3'b011,
		ISRP_WRITE = 3'b010,
		ISRP_READ = 3'b110
	} isrp_state_e;
endpackage
`default_nettype wire

// file: logic/isrp_slave.sv
// Purpose: Two-wire slave with auto-incrementing register pointer
// Assumes: scl and sda from pins, synchronised here; open-drain output
// Notes: sda_oe_b low means the pin is pulled low
`timescale 1ns/10ps
`default_nettype none
module isrp_slave (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_oe_b,
	input wire logic addr_select_hi_pin,
	input wire logic addr_select_lo_pin,
	output logic [8*isrp_pkg::NUM_REGS-1:0] reg_flat,
	output logic wr_strobe
);
	logic [1:0] scl_s_q, sda_s_q;
	logic scl_q, sda_q;
	logic [1:0] sel_s_q, sel_q;
	isrp_pkg::isrp_state_e st_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q, ptr_q, tx_q;
	logic rw_q, have_ptr_q, in_frame_q, ack_q, drive_q, nack_q, ack_due_q, in_frame_rs_q;
	logic [7:0] regs_q [isrp_pkg::NUM_REGS];

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			scl_s_q <= 2'h3;
			sda_s_q <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			sel_s_q <= 2'h0;
			sel_q <= 2'h0;
		end else begin
			scl_s_q <= {scl_s_q[0], scl_in};
			sda_s_q <= {sda_s_q[0], sda_in};
			scl_q <= scl_s_q[1];
			sda_q <= sda_s_q[1];
			sel_s_q <= {addr_select_hi_pin, addr_select_lo_pin};
			sel_q <= sel_s_q;
		end
	end

	wire scl_now = scl_s_q[1];
	wire sda_now = sda_s_q[1];
	wire scl_rise = scl_now && !scl_q;
	wire scl_fall = !scl_now && scl_q;
	wire start_ev = scl_now && scl_q && sda_q && !sda_now;
	wire stop_ev = scl_now && scl_q && !sda_q && sda_now; // [R3]
	wire [6:0] my_addr = {isrp_pkg::ADDR_FIXED, sel_q}; // [R1]
	wire [7:0] byte_in = {sh_q[6:0], sda_now};
	// Pointers past the last register read as zero
	wire [7:0] rd_byte = (ptr_q < 8'(isrp_pkg::NUM_REGS)) ? regs_q[ptr_q[3:0]] : 8'h00;

	function automatic logic [7:0] ptr_next(input logic [7:0] p);
		ptr_next = (p >= isrp_pkg::PTR_TOP) ? isrp_pkg::PTR_TOP : p + 8'h01;
	endfunction

	// Bit and byte sequencing; sampling on scl rise, driving on scl fall
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			st_q <= isrp_pkg::ISRP_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			rw_q <= 1'b0;
			have_ptr_q <= 1'b0;
			in_frame_q <= 1'b0;
			ack_q <= 1'b0;
			ack_due_q <= 1'b0;
			nack_q <= 1'b0;
		end else if (stop_ev) begin
			st_q <= isrp_pkg::ISRP_IDLE;
			in_frame_q <= 1'b0; // [R13]
			ack_q <= 1'b0;
			ack_due_q <= 1'b0;
		end else if (start_ev) begin
			st_q <= isrp_pkg::ISRP_ADDR;
			bit_q <= 4'h0;
			in_frame_q <= 1'b1;
			ack_q <= 1'b0;
			ack_due_q <= 1'b0;
		end else if (scl_rise && st_q != isrp_pkg::ISRP_IDLE) begin
			if (bit_q == isrp_pkg::BIT_LAST) begin
				bit_q <= 4'h0;
				nack_q <= sda_now;
			end else begin
				sh_q <= byte_in;
				bit_q <= bit_q + 4'h1;
			end
			if (bit_q == 4'h7) begin
				case (st_q)
					isrp_pkg::ISRP_ADDR: begin
						if (byte_in[7:1] == my_addr) begin
							rw_q <= byte_in[0];
							have_ptr_q <= 1'b0;
							ack_due_q <= 1'b1; // [R10] [R2]
							st_q <= byte_in[0] ? isrp_pkg::ISRP_READ : isrp_pkg::ISRP_ACK;
						end else begin
							st_q <= isrp_pkg::ISRP_IDLE;
						end
					end
					isrp_pkg::ISRP_ACK, isrp_pkg::ISRP_WRITE: begin
						ack_due_q <= 1'b1; // [R5] [R6]
						have_ptr_q <= 1'b1;
						st_q <= isrp_pkg::ISRP_WRITE;
					end
					default: ;
				endcase
			end
		end else if (scl_fall && bit_q == isrp_pkg::BIT_LAST) begin
			// Ack waits for scl low; data moving while scl is high reads as start or stop
			ack_q <= ack_due_q; // [R2] [R5] [R10]
			ack_due_q <= 1'b0;
		end else if (scl_fall && bit_q == 4'h0) begin
			ack_q <= 1'b0;
			if (st_q == isrp_pkg::ISRP_READ && rw_q && nack_q && !ack_q)
				st_q <= isrp_pkg::ISRP_IDLE; // [R16]
		end
	end

	// Register pointer
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ptr_q <= isrp_pkg::PTR_RESET;
		end else if (scl_rise && bit_q == 4'h7) begin
			if (st_q == isrp_pkg::ISRP_ADDR && byte_in[7:1] == my_addr && byte_in[0] && !in_frame_rs_q)
				ptr_q <= isrp_pkg::PTR_RESET; // [R9] [R17]
			else if (st_q == isrp_pkg::ISRP_ACK)
				ptr_q <= byte_in; // [R4] [R14]
			else if (st_q == isrp_pkg::ISRP_WRITE)
				ptr_q <= ptr_next(ptr_q); // [R7] [R8]
			else if (st_q == isrp_pkg::ISRP_READ)
				ptr_q <= ptr_next(ptr_q); // [R12] [R15]
		end
	end

	// A start while a frame is open is a repeated start
	always_ff @(posedge clock) begin
		if (!rst_b)
			in_frame_rs_q <= 1'b0;
		else if (stop_ev)
			in_frame_rs_q <= 1'b0;
		else if (start_ev)
			in_frame_rs_q <= in_frame_q;
	end

	// Register storage
	wire wr_now = scl_rise && bit_q == 4'h7 && st_q == isrp_pkg::ISRP_WRITE && have_ptr_q;
	genvar gi;
	generate
		for (gi = 0; gi < isrp_pkg::NUM_REGS; gi++) begin : g_reg
			always_ff @(posedge clock) begin
				if (!rst_b)
					regs_q[gi] <= 8'h00;
				else if (wr_now && ptr_q == 8'(gi))
					regs_q[gi] <= byte_in; // [R6]
			end
			assign reg_flat[8*gi +: 8] = regs_q[gi];
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (!rst_b)
			wr_strobe <= 1'b0;
		else
			wr_strobe <= wr_now;
	end

	// Read data shifts out on scl fall, stable by the next rise
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			tx_q <= 8'h00;
			drive_q <= 1'b0;
		end else if (stop_ev || start_ev) begin
			drive_q <= 1'b0;
		end else if (scl_fall && st_q == isrp_pkg::ISRP_READ) begin
			if (bit_q == 4'h0 && !(nack_q && !ack_q)) begin
				tx_q <= {rd_byte[6:0], 1'b0};
				drive_q <= !rd_byte[7]; // [R11]
			end else if (bit_q != 4'h0 && bit_q < isrp_pkg::BIT_LAST) begin
				tx_q <= {tx_q[6:0], 1'b0};
				drive_q <= !tx_q[7];
			end else begin
				drive_q <= 1'b0;
			end
		end else if (scl_fall) begin
			drive_q <= 1'b0;
		end
	end

	assign sda_oe_b = !(ack_q || (drive_q && st_q == isrp_pkg::ISRP_READ));

	a_ack_nine: assert property (@(posedge clock) disable iff (!rst_b) // [R2]
		(scl_rise && bit_q == isrp_pkg::BIT_LAST && ack_q) |-> !sda_oe_b)
		else $error("ack not driven on ninth clock");
	a_pull_scl_low: assert property (@(posedge clock) disable iff (!rst_b) // [R11]
		$fell(sda_oe_b) |-> !scl_now)
		else $error("data pulled low while scl high");
	a_ptr_sat: assert property (@(posedge clock) disable iff (!rst_b) // [R8] [R15]
		(scl_rise && bit_q == 4'h7 && (st_q == isrp_pkg::ISRP_WRITE || st_q == isrp_pkg::ISRP_READ)
		&& ptr_q == isrp_pkg::PTR_TOP) |=> ptr_q == isrp_pkg::PTR_TOP)
		else $error("pointer moved past top");
	a_stop_idle: assert property (@(posedge clock) disable iff (!rst_b) // [R3]
		stop_ev |=> st_q == isrp_pkg::ISRP_IDLE)
		else $error("stop not honoured");
	a_read_zero: assert property (@(posedge clock) disable iff (!rst_b) // [R9]
		(scl_rise && bit_q == 4'h7 && st_q == isrp_pkg::ISRP_ADDR && byte_in == {my_addr, 1'b1}
		&& !in_frame_rs_q) |=> ptr_q == isrp_pkg::PTR_RESET)
		else $error("read pointer not zeroed");
	a_read_keep: assert property (@(posedge clock) disable iff (!rst_b) // [R17]
		(scl_rise && bit_q == 4'h7 && st_q == isrp_pkg::ISRP_ADDR && byte_in == {my_addr, 1'b1}
		&& in_frame_rs_q) |=> ptr_q == $past(ptr_q))
		else $error("preset pointer lost on repeated start");
	a_addr_refuse: assert property (@(posedge clock) disable iff (!rst_b) // [R1]
		(scl_rise && bit_q == 4'h7 && st_q == isrp_pkg::ISRP_ADDR && byte_in[7:1] != my_addr)
		|=> (st_q == isrp_pkg::ISRP_IDLE && !ack_due_q))
		else $error("foreign address accepted");
	a_write_inc: assert property (@(posedge clock) disable iff (!rst_b) // [R7]
		(wr_now && ptr_q < isrp_pkg::PTR_TOP) |=> ptr_q == $past(ptr_q) + 8'h01)
		else $error("pointer not advanced");
	a_ptr_load: assert property (@(posedge clock) disable iff (!rst_b) // [R4]
		(scl_rise && bit_q == 4'h7 && st_q == isrp_pkg::ISRP_ACK)
		|=> ptr_q == $past(byte_in))
		else $error("pointer byte not loaded");
endmodule
`default_nettype wire

// file: verif/isrp_mst.sv
// Purpose: Bus master model driving the pointer slave
// Assumes: Bit period 12 clocks, 48 ns; sda pulled up
// Notes: sda_low high pulls the data line low
`timescale 1ns/10ps
`default_nettype none
module isrp_mst (
	input wire logic clock,
	input wire logic sda,
	output var logic scl,
	output var logic sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic bitx(input logic b, output logic r);
		w(3);
		sda_low <= !b;
		w(3);
		scl <= 1'b1;
		w(6);
		r = sda;
		scl <= 1'b0;
	endtask
	// Stop never shares the high pulse of a start
	task automatic start();
		w(6);
		sda_low <= 1'b0;
		w(3);
		scl <= 1'b1;
		w(6);
		sda_low <= 1'b1;
		w(6);
		scl <= 1'b0;
	endtask
	task automatic stop();
		w(3);
		sda_low <= 1'b1;
		w(3);
		scl <= 1'b1;
		w(6);
		sda_low <= 1'b0;
		w(6);
	endtask
	// b9 low acknowledges a read byte, high ends the read
	task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] q, output logic r9);
		for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
		bitx(b9, r9);
	endtask
endmodule
`default_nettype wire

// file: verif/tb.sv
// Purpose: Self-checking bench for the pointer slave
// Assumes: Register model kept in the bench
// Notes: Pointers stay within 0 to 11
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clock = 1'b0, rst_b = 1'b0, hi = 1'b0, lo = 1'b0, scl, sda, sda_low, sda_oe_b, wr_strobe, r;
	logic [8*isrp_pkg::NUM_REGS-1:0] reg_flat;
	logic [7:0] q, d, mdl[isrp_pkg::NUM_REGS];
	int mismatches = 0, checked = 0, ptr, strobes = 0, s0;
	always #2 clock = ~clock;
	always @(negedge clock) if (wr_strobe === 1'b1) strobes++;
	assign sda = !(sda_low || !sda_oe_b);
	isrp_slave u_isrp_slave (.clock(clock), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_oe_b(sda_oe_b),
		.addr_select_hi_pin(hi), .addr_select_lo_pin(lo), .reg_flat(reg_flat), .wr_strobe(wr_strobe));
	isrp_mst u_isrp_mst (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic sa(input logic rd, input logic [1:0] sel, input logic ack);
		u_isrp_mst.start();
		u_isrp_mst.xfer({isrp_pkg::ADDR_FIXED, sel, rd}, 1'b1, q, r);
		chk("addr ack", {7'h00, !ack}, {7'h00, r});
	endtask
	task automatic ptrset(input logic [7:0] p);
		sa(1'b0, {hi, lo}, 1'b1);
		u_isrp_mst.xfer(p, 1'b1, q, r);
		chk("ptr ack", 8'h00, {7'h00, r});
		ptr = p;
	endtask
	task automatic wr(input logic [7:0] p, input int n);
		s0 = strobes;
		ptrset(p);
		repeat (n) begin
			d = 8'($urandom);
			u_isrp_mst.xfer(d, 1'b1, q, r);
			chk("data ack", 8'h00, {7'h00, r});
			mdl[ptr] = d;
			if (ptr < 11) ptr++;
		end
		u_isrp_mst.stop();
		for (int i = 0; i < 12; i++) chk("reg", mdl[i], reg_flat[8*i+:8]);
		chk("strobes", 8'(n), 8'(strobes - s0));
		$display("write test done");
	endtask
	task automatic rd(input logic rs, input int n);
		if (!rs) ptr = 0;
		sa(1'b1, {hi, lo}, 1'b1);
		for (int i = 0; i < n; i++) begin
			u_isrp_mst.xfer(8'hFF, i == n - 1, q, r);
			chk("read", mdl[ptr], q);
			if (ptr < 11) ptr++;
		end
		u_isrp_mst.stop();
		$display("read test done");
	endtask
	initial begin
		void'($urandom(32'h5FDF));
		for (int i = 0; i < 12; i++) mdl[i] = 8'h00;
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		{hi, lo} <= 2'($urandom);
		repeat (10) @(posedge clock);
		wr(8'h00, 12);
		wr(8'h0A, 4);
		rd(1'b0, 13);
		ptrset(8'(1 + $urandom % 11));
		rd(1'b1, 3);
		rd(1'b0, 2);
		sa(1'b0, {hi, lo} ^ 2'h1, 1'b0);
		u_isrp_mst.stop();
		$display("address test done");
		give_verdict();
	end
	initial begin
		repeat (30000) @(posedge clock);
		mismatches++;
		give_verdict();
	end
endmodule
`default_nettype wire
